// ### hw/aiq_params.svh
`ifndef AIQ_PARAMS_SVH
`define AIQ_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define AIQ_IDX_SCLK_STEP 12'h067
`define AIQ_IDX_SCLK_MOD 12'h068
`define AIQ_IDX_MCLK_STEP 12'h06c
`define AIQ_IDX_MCLK_MOD 12'h06d
`define AIQ_IDX_Q0_BASE_LO 12'hb00
`define AIQ_IDX_Q0_BASE_MID 12'hb01
`define AIQ_IDX_Q0_DEPTH 12'hb02
`define AIQ_IDX_Q0_BASE_HI 12'hb03
`define AIQ_IDX_Q1_BASE_LO 12'hb04
`define AIQ_IDX_Q1_BASE_MID 12'hb05
`define AIQ_IDX_Q1_DEPTH 12'hb06
`define AIQ_IDX_Q1_BASE_HI 12'hb07
`define AIQ_IDX_Q2_BASE_LO 12'hb08
`define AIQ_IDX_Q2_BASE_MID 12'hb09
`define AIQ_IDX_Q2_DEPTH 12'hb0a
`define AIQ_IDX_Q2_BASE_HI 12'hb0b
`define AIQ_IDX_Q0_LOW_TH 12'hb0c
`define AIQ_IDX_Q0_HIGH_TH 12'hb0d
`define AIQ_IDX_Q1_HIGH_TH 12'hb0e
`define AIQ_IDX_Q2_HIGH_TH 12'hb0f
`define AIQ_IDX_CTRL 12'hb10
`define AIQ_IDX_SRC_SEL 12'hb11
`define AIQ_IDX_STATUS 12'hb13
`define AIQ_IDX_CNT_FIRST 12'hb20
`define AIQ_IDX_CNT_LAST 12'hb25

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AIQ_RST_SCLK_STEP 8'h00
`define AIQ_RST_SCLK_MOD 8'h02
`define AIQ_RST_MCLK_STEP 8'h01
`define AIQ_RST_MCLK_MOD 8'h02
`define AIQ_RST_BASE_LO 8'h00
`define AIQ_RST_Q0_BASE_MID 8'h40
`define AIQ_RST_Q1_BASE_MID 8'h48
`define AIQ_RST_Q2_BASE_MID 8'h3c
`define AIQ_RST_BASE_HI 8'h04
`define AIQ_RST_Q01_DEPTH 8'h7f
`define AIQ_RST_Q2_DEPTH 8'h3f
`define AIQ_RST_Q0_LOW_TH 8'h20
`define AIQ_RST_Q0_HIGH_TH 8'h60
`define AIQ_RST_Q12_HIGH_TH 8'h20
`define AIQ_RST_CTRL 8'hf9
`define AIQ_RST_SRC_SEL 8'h21

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AIQ_CLK_EN_BIT 7
`define AIQ_CTRL_PLAY_BIT 3
`define AIQ_CTRL_IRQ_LSB 4
`define AIQ_SEL_Q0_LSB 2
`define AIQ_SEL_Q1_LSB 4
`define AIQ_SEL_MIC_L_BIT 6
`define AIQ_SEL_MIC_R_BIT 7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AIQ_SRC_HZ 48000000
`define AIQ_MCLK_HZ 100000000
`define AIQ_UNIT_HZ 1000000

`endif

// ### hw/aiq_pkg.sv
package aiq_pkg;

   // ----------------------------------------------------------------
   // Audio sample sources
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      AIQ_SRC_USB = 3'h0,
      AIQ_SRC_I2S = 3'h1,
      AIQ_SRC_MIC_L = 3'h2,
      AIQ_SRC_MIC_R = 3'h3,
      AIQ_SRC_AUX = 3'h4
   } aiq_src_t;

   // Source selection codes of queues 0 and 1
   typedef enum logic [1:0]
   {
      AIQ_SEL_USB = 2'h0,
      AIQ_SEL_I2S = 2'h1,
      AIQ_SEL_MIC16 = 2'h2,
      AIQ_SEL_MIC20 = 2'h3
   } aiq_sel_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed
   {
      aiq_src_t src;
      logic [31:0] data;
   } aiq_sample_t;

   typedef struct packed
   {
      logic [18:0] addr;
      logic [31:0] data;
   } aiq_sram_req_t;

endpackage

// ### hw/aiq_top.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`include "aiq_params.svh"

// Behaviour
// - Serial audio clock runs only when enabled, at 48M*step/modulus.
// - Codec master clock runs only when enabled, at 48M*step/modulus.
// - Queue base address is 19 bits from three byte registers.
// - Queue size is depth register times four words.
// - A queue accepts input only while its enable bit is set.
// - Queue 0 feeds the output path only while bit 3 is set.
// - Each watermark interrupt is forwarded only while its mask bit is set.
// - Queue 0 source: USB, I2S, 16-bit mic, 20-bit left mic.
// - Queue 1 source: USB, I2S, 16-bit mic, 20-bit right mic.
// - Bits 6 and 7 enable left and right microphone channels.
// - Queue 0 below low threshold sets sticky and live low flags.
// - Live flags clear themselves; software clears sticky flags.
// - Queue above high threshold sets sticky and live high flags.
module aiq_top
#(
   parameter int ADDR_W = 14
)
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic in_valid,
   input wire aiq_pkg::aiq_sample_t in_sample,
   output logic in_ready,
   output logic sram_valid,
   output aiq_pkg::aiq_sram_req_t sram_req,
   input wire logic sram_ready,
   input wire logic [2:0] q_pop,
   output logic sclk_out,
   output logic codec_mclk_out,
   output logic [3:0] irq
);

   // ----------------------------------------------------------------
   // Constants and elaboration check
   // ----------------------------------------------------------------
   localparam int NCFG = 22;
   localparam int PTR_W = 10;
   localparam logic [5:0] SLOT_STATUS = 6'd22;
   localparam logic [5:0] SLOT_CNT = 6'd23;
   localparam logic [5:0] SLOT_NONE = 6'd63;
   localparam int INC_K = 2 * (`AIQ_SRC_HZ / `AIQ_UNIT_HZ);
   localparam int MOD_K = `AIQ_MCLK_HZ / `AIQ_UNIT_HZ;
   localparam logic [7:0] CFG_RST [0:NCFG-1] = '{
      `AIQ_RST_SCLK_STEP, `AIQ_RST_SCLK_MOD,
      `AIQ_RST_MCLK_STEP, `AIQ_RST_MCLK_MOD,
      `AIQ_RST_BASE_LO, `AIQ_RST_Q0_BASE_MID,
      `AIQ_RST_Q01_DEPTH, `AIQ_RST_BASE_HI,
      `AIQ_RST_BASE_LO, `AIQ_RST_Q1_BASE_MID,
      `AIQ_RST_Q01_DEPTH, `AIQ_RST_BASE_HI,
      `AIQ_RST_BASE_LO, `AIQ_RST_Q2_BASE_MID,
      `AIQ_RST_Q2_DEPTH, `AIQ_RST_BASE_HI,
      `AIQ_RST_Q0_LOW_TH, `AIQ_RST_Q0_HIGH_TH,
      `AIQ_RST_Q12_HIGH_TH, `AIQ_RST_Q12_HIGH_TH,
      `AIQ_RST_CTRL, `AIQ_RST_SRC_SEL};

   if (ADDR_W < 14)
   begin : g_bad_addr
      $error("aiq_top: ADDR_W must be at least 14");
   end

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Register index to storage slot
   function automatic logic [5:0] aiq_slot(input logic [11:0] idx);
      logic [5:0] s;
      s = SLOT_NONE;
      if (idx == `AIQ_IDX_SCLK_STEP)
         s = 6'd0;
      else if (idx == `AIQ_IDX_SCLK_MOD)
         s = 6'd1;
      else if (idx == `AIQ_IDX_MCLK_STEP)
         s = 6'd2;
      else if (idx == `AIQ_IDX_MCLK_MOD)
         s = 6'd3;
      else if (idx >= `AIQ_IDX_Q0_BASE_LO && idx <= `AIQ_IDX_SRC_SEL)
         s = 6'(idx - `AIQ_IDX_Q0_BASE_LO) + 6'd4;
      else if (idx == `AIQ_IDX_STATUS)
         s = SLOT_STATUS;
      else if (idx >= `AIQ_IDX_CNT_FIRST && idx <= `AIQ_IDX_CNT_LAST)
         s = 6'(idx - `AIQ_IDX_CNT_FIRST) + SLOT_CNT;
      return s;
   endfunction

   // Pointer advance with wrap at the queue size
   function automatic logic [PTR_W-1:0] aiq_wrap(
      input logic [PTR_W-1:0] ptr,
      input logic [PTR_W-1:0] size);
      logic [PTR_W-1:0] n;
      n = ptr + 10'd1;
      return (n >= size) ? '0 : n;
   endfunction

   // Does a sample of this source belong to a queue with this select code
   function automatic logic aiq_match(
      input logic [1:0] sel,
      input aiq_pkg::aiq_src_t src,
      input aiq_pkg::aiq_src_t mic,
      input logic mic_en);
      logic m;
      m = 1'b0;
      unique case (aiq_pkg::aiq_sel_t'(sel))
         aiq_pkg::AIQ_SEL_USB: m = (src == aiq_pkg::AIQ_SRC_USB);
         aiq_pkg::AIQ_SEL_I2S: m = (src == aiq_pkg::AIQ_SRC_I2S);
         aiq_pkg::AIQ_SEL_MIC16,
         aiq_pkg::AIQ_SEL_MIC20: m = (src == mic) && mic_en;
      endcase
      return m;
   endfunction

   // Sample word as stored for a select code
   function automatic logic [31:0] aiq_fmt(
      input logic [1:0] sel,
      input logic [31:0] d);
      logic [31:0] w;
      w = d;
      if (sel == aiq_pkg::AIQ_SEL_MIC16)
         w = {16'h0000, d[15:0]};
      else if (sel == aiq_pkg::AIQ_SEL_MIC20)
         w = {12'h000, d[19:0]};
      return w;
   endfunction

   // ----------------------------------------------------------------
   // Register storage and bus decode
   // ----------------------------------------------------------------
   logic [7:0] cfg_r [0:NCFG-1];
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [3:0] sticky_r;
   logic [3:0] irq_r;
   logic in_ready_r;
   logic [1:0] vld_r;
   aiq_pkg::aiq_sram_req_t ent_r [0:1];
   // Live watermark levels: [0] q0 low, [3:1] q0..q2 high
   logic [3:0] live;
   logic [PTR_W-1:0] cnt [0:2];
   logic [2:0] full;
   logic [7:0] rd_byte;

   // Bus phase decode
   wire setup = psel & ~penable;
   wire commit = psel & penable & pready_r;
   wire [5:0] slot = aiq_slot(paddr[13:2]);
   wire hit = (slot != SLOT_NONE);
   wire wr_cfg = commit & pwrite & (slot < 6'(NCFG));
   wire wr_status = commit & pwrite & (slot == SLOT_STATUS);
   wire [7:0] ctrl = cfg_r[20];
   wire [7:0] srcsel = cfg_r[21];
   wire [5:0] cnt_slot = slot - SLOT_CNT;
   wire [PTR_W-1:0] cnt_sel = cnt[cnt_slot[2:1]];

   // Read data selection
   assign rd_byte = (slot < 6'(NCFG)) ? cfg_r[slot[4:0]] :
                    (slot == SLOT_STATUS) ? {live, sticky_r} :
                    (slot == SLOT_NONE) ? 8'h00 :
                    cnt_slot[0] ? {6'h00, cnt_sel[9:8]} : cnt_sel[7:0];

   // Bus answer: ready in the first access cycle
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= setup;
         pslverr_r <= setup & ~hit;
         if (setup)
            prdata_r <= {24'h00_0000, rd_byte};
      end
   end

   // Configuration registers
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         for (int i = 0; i < NCFG; i++)
            cfg_r[i] <= CFG_RST[i];
      end
      else if (wr_cfg)
         cfg_r[slot[4:0]] <= pwdata[7:0];
   end

   // ----------------------------------------------------------------
   // Input routing
   // ----------------------------------------------------------------
   wire [1:0] sel0 = srcsel[`AIQ_SEL_Q0_LSB +: 2];
   wire [1:0] sel1 = srcsel[`AIQ_SEL_Q1_LSB +: 2];
   wire accept = in_valid & in_ready_r;
   // Source match for each queue
   wire m0 = aiq_match(sel0, in_sample.src, aiq_pkg::AIQ_SRC_MIC_L,
                       srcsel[`AIQ_SEL_MIC_L_BIT]);
   wire m1 = aiq_match(sel1, in_sample.src, aiq_pkg::AIQ_SRC_MIC_R,
                       srcsel[`AIQ_SEL_MIC_R_BIT]);
   wire m2 = (in_sample.src == aiq_pkg::AIQ_SRC_AUX);
   // Queue admits only while enabled and not full
   wire [2:0] ok = {m2, m1, m0} & ctrl[2:0] & ~full;
   wire [2:0] tgt = ok[0] ? 3'b001 : ok[1] ? 3'b010 : {ok[2], 2'b00};
   wire [2:0] push_q = tgt & {3{accept}};
   wire [31:0] word = ok[0] ? aiq_fmt(sel0, in_sample.data) :
                      ok[1] ? aiq_fmt(sel1, in_sample.data) :
                      in_sample.data;
   logic [18:0] waddr [0:2];
   wire [18:0] push_addr = tgt[0] ? waddr[0] : tgt[1] ? waddr[1] : waddr[2];

   // ----------------------------------------------------------------
   // Queue pointers and watermarks
   // ----------------------------------------------------------------
   for (genvar q = 0; q < 3; q++)
   begin : g_queue
      logic [PTR_W-1:0] wptr_r;
      logic [PTR_W-1:0] rptr_r;
      wire [18:0] base = {cfg_r[7+4*q][2:0], cfg_r[5+4*q],
                          cfg_r[4+4*q]};
      wire [PTR_W-1:0] size = {cfg_r[6+4*q], 2'b00};
      wire clr = wr_cfg & (slot == 6'(6 + 4 * q));
      wire play_ok = (q != 0) | ctrl[`AIQ_CTRL_PLAY_BIT];
      wire pop = q_pop[q] & (cnt[q] != '0) & play_ok;
      // Occupancy with wrap
      assign cnt[q] = (wptr_r >= rptr_r) ? wptr_r - rptr_r :
                      wptr_r + size - rptr_r;
      assign full[q] = (size == '0) | (cnt[q] == size - 10'd1);
      assign waddr[q] = 19'(base + {7'h00, wptr_r, 2'b00});
      assign live[q+1] = cnt[q] > {2'b00, cfg_r[17+q]};

      // Pointers; a depth write restarts the queue
      always_ff @(posedge mclk)
      begin
         if (srst | clr)
         begin
            wptr_r <= '0;
            rptr_r <= '0;
         end
         else
         begin
            if (push_q[q])
               wptr_r <= aiq_wrap(wptr_r, size);
            if (pop)
               rptr_r <= aiq_wrap(rptr_r, size);
         end
      end
   end

   assign live[0] = cnt[0] < {2'b00, cfg_r[16]};

   // Sticky flags: a new event wins over a clear
   // A live level keeps its sticky bit set through any clear attempt
   wire [3:0] clr_mask = wr_status ? pwdata[3:0] : 4'h0;
   wire [3:0] sticky_nxt = (sticky_r & ~clr_mask) | live;
   wire [3:0] irq_nxt = sticky_nxt & ctrl[`AIQ_CTRL_IRQ_LSB +: 4];

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         sticky_r <= 4'h0;
         irq_r <= 4'h0;
      end
      else
      begin
         sticky_r <= sticky_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Two-entry buffer toward the SRAM
   // ----------------------------------------------------------------
   wire pop_b = vld_r[0] & sram_ready;
   wire push_b = |push_q;
   aiq_pkg::aiq_sram_req_t new_ent;
   aiq_pkg::aiq_sram_req_t ent0_nxt;
   aiq_pkg::aiq_sram_req_t ent1_nxt;
   logic [1:0] vld_nxt;
   logic [1:0] vld_sh;

   assign new_ent = '{addr: push_addr, data: word};
   assign vld_sh = pop_b ? {1'b0, vld_r[1]} : vld_r;
   assign ent0_nxt = (pop_b & vld_r[1]) ? ent_r[1] :
                     (push_b & ~vld_sh[0]) ? new_ent : ent_r[0];
   assign ent1_nxt = (push_b & vld_sh[0]) ? new_ent : ent_r[1];
   assign vld_nxt = push_b ? (vld_sh[0] ? 2'b11 : 2'b01) : vld_sh;

   // Buffer state; ready reflects room for the next cycle
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         vld_r <= 2'b00;
         in_ready_r <= 1'b0;
         ent_r[0] <= '0;
         ent_r[1] <= '0;
      end
      else
      begin
         vld_r <= vld_nxt;
         in_ready_r <= ~vld_nxt[1];
         ent_r[0] <= ent0_nxt;
         ent_r[1] <= ent1_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Fractional clock dividers
   // ----------------------------------------------------------------
   // Modulus of at least twice the step keeps toggles under mclk rate
   for (genvar d = 0; d < 2; d++)
   begin : g_div
      // Accumulator and output level owned by this divider alone
      logic [15:0] acc_r;
      logic tog_r;
      wire [7:0] step = cfg_r[2*d];
      wire [7:0] modv = cfg_r[2*d+1];
      wire en = step[`AIQ_CLK_EN_BIT] & (modv != 8'h00);
      wire [15:0] inc = 16'(step[6:0] * INC_K);
      wire [15:0] lim = 16'(modv * MOD_K);
      wire [16:0] sum = {1'b0, acc_r} + {1'b0, inc};
      wire wrap = sum >= {1'b0, lim};

      // Half period per wrap gives 48M*step/mod
      always_ff @(posedge mclk)
      begin
         if (srst | ~en)
         begin
            acc_r <= 16'h0000;
            tog_r <= 1'b0;
         end
         else if (wrap)
         begin
            acc_r <= 16'(sum - {1'b0, lim});
            tog_r <= ~tog_r;
         end
         else
            acc_r <= sum[15:0];
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign in_ready = in_ready_r;
   assign sram_valid = vld_r[0];
   assign sram_req = ent_r[0];
   // Divider levels leave straight from their toggle flops
   assign sclk_out = g_div[0].tog_r;
   assign codec_mclk_out = g_div[1].tog_r;
   assign irq = irq_r;

endmodule

// ### tb/aiq_top_chk.sv
`timescale 1ns/1ns
// ------------------------------
// Port checker for the queue block
// ------------------------------
module aiq_top_chk
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sram_valid,
   input wire aiq_pkg::aiq_sram_req_t sram_req,
   input wire logic sram_ready,
   input wire logic sclk_out,
   input wire logic codec_mclk_out,
   input wire logic [3:0] irq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   // Bus answers, reset state, stream hold, clocks and flags
   a_setup_ready: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_read: assert property (pslverr && !pwrite |-> pready && !prdata)
      else $error("refused read not zero");
   a_reset_idle: assert property (disable iff (1'b0) srst |=>
      !pready && !sram_valid && irq == 4'h0 && !sclk_out && !codec_mclk_out)
      else $error("outputs busy after reset");
   a_sclk_rate: assert property ($changed(sclk_out) |=> $stable(sclk_out))
      else $error("serial clock too fast");
   a_mclk_rate: assert property ($changed(codec_mclk_out) |=> $stable(codec_mclk_out))
      else $error("codec clock too fast");
   a_sram_hold: assert property (sram_valid && !sram_ready |=>
      sram_valid && $stable(sram_req))
      else $error("word changed while stalled");
   a_addr_align: assert property (sram_valid |-> sram_req.addr[1:0] == 2'h0)
      else $error("word address misaligned");
   a_irq_clear: assert property (|($past(irq) & ~irq) |->
      $past(psel && pwrite) || $past(psel && pwrite, 2) || $past(psel && pwrite, 3))
      else $error("flag dropped without a write");
   a_irq_start: assert property ($fell(srst) |-> ##[0:3] irq[0])
      else $error("low flag missing after reset");

   // Main scenarios reached
   c_refused: cover property (pslverr);
   c_stall: cover property (sram_valid && !sram_ready);
   c_high: cover property ($rose(irq[1]));
endmodule

bind aiq_top aiq_top_chk i_aiq_top_chk (.mclk, .srst, .psel, .penable,
   .pwrite, .prdata, .pready, .pslverr, .sram_valid, .sram_req,
   .sram_ready, .sclk_out, .codec_mclk_out, .irq);

// ### tb/aiq_sram_model.sv
`timescale 1ns/1ns
// ------------------------------
// SRAM write port model
// ------------------------------
module aiq_sram_model
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic sram_valid,
   input wire aiq_pkg::aiq_sram_req_t sram_req,
   input wire logic [1:0] mode,
   output logic sram_ready
);
   aiq_pkg::aiq_sram_req_t log_q[$];

   initial sram_ready = 1'b0;

   // Logs each taken word; ready is prompt, every other cycle or stalled
   always @(posedge mclk)
   begin
      if (sram_valid && sram_ready && !srst)
         log_q.push_back(sram_req);
      if (srst || mode == 2'h2)
         sram_ready <= 1'b0;
      else
         sram_ready <= (mode == 2'h0) ? 1'b1 : ~sram_ready;
   end
endmodule

// ### tb/aiq_top_tb.sv
`timescale 1ns/1ns
module aiq_top_tb;
   // ------------------------------
   // Signals and counters
   // ------------------------------
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [13:0] paddr = 14'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic in_valid = 1'b0;
   aiq_pkg::aiq_sample_t in_sample = '0;
   logic in_ready;
   logic sram_valid;
   aiq_pkg::aiq_sram_req_t sram_req;
   logic sram_ready;
   logic [2:0] q_pop = 3'h0;
   logic [1:0] mode = 2'h0;
   logic sclk_out;
   logic codec_mclk_out;
   logic [3:0] irq;
   int fail_count = 0;
   int comparisons = 0;
   localparam logic [143:0] RST =
      144'h21f9_2020_6020_043f_3c00_047f_4800_047f_4000;

   always #5 mclk = ~mclk;

   aiq_top i_aiq_top (.mclk, .srst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_sample,
      .in_ready, .sram_valid, .sram_req, .sram_ready, .q_pop,
      .sclk_out, .codec_mclk_out, .irq);
   aiq_sram_model i_aiq_sram_model (.mclk, .srst, .sram_valid,
      .sram_req, .mode, .sram_ready);

   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] i,
      input logic [7:0] d, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'h0};
      pwdata <= {24'h00_0000, d};
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk(n < 20, 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wr(input logic [11:0] i, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, i, d, r, e);
      chk(e, 1'b0);
   endtask

   task automatic rd(input logic [11:0] i, input logic [7:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, i, 8'h00, r, e);
      chk({e, r}, {9'h000, 24'h00_0000, x});
   endtask

   task automatic send(input logic [2:0] s, input logic [31:0] d);
      int n;
      n = 0;
      in_valid <= 1'b1;
      in_sample <= {s, d};
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (in_ready !== 1'b1 && n < 50);
      chk(n < 50, 1'b1);
   endtask

   task automatic stop();
      in_valid <= 1'b0;
   endtask

   task automatic got(input logic [18:0] a, input logic [31:0] d);
      int n;
      n = 0;
      while (i_aiq_sram_model.log_q.size() == 0 && n < 50)
      begin
         @(posedge mclk);
         n++;
      end
      if (n == 50)
         chk(1'b0, 1'b1);
      else
         chk(i_aiq_sram_model.log_q.pop_front(), {a, d});
   endtask

   task automatic pop(input logic [2:0] m);
      q_pop <= m;
      @(posedge mclk);
      q_pop <= 3'h0;
      @(posedge mclk);
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      chk(irq, 4'h1);
      for (int k = 0; k < 18; k++)
         rd(12'hb00 + 12'(k), RST[8*k +: 8]);
      rd(12'h067, 8'h00);
      rd(12'h068, 8'h02);
      rd(12'h06c, 8'h01);
      rd(12'h06d, 8'h02);
      apb(1'b0, 12'h000, 8'h00, r, e);
      chk({e, r}, {1'b1, 32'h0000_0000});
      apb(1'b1, 12'hfff, 8'h5a, r, e);
      chk(e, 1'b1);
   endtask

   task automatic t_stream();
      mode <= 2'h2;
      send(3'h0, 32'h1111_0000);
      send(3'h0, 32'h1111_0001);
      stop();
      repeat (2) @(posedge mclk);
      chk(in_ready, 1'b0);
      mode <= 2'h1;
      send(3'h0, 32'h1111_0002);
      stop();
      for (int k = 0; k < 3; k++)
         got(19'h4_4000 + 19'(4*k), 32'h1111_0000 + 32'(k));
      rd(12'hb20, 8'h03);
      pop(3'h1);
      rd(12'hb20, 8'h02);
      wr(12'hb10, 8'hf1);
      pop(3'h1);
      rd(12'hb20, 8'h02);
      mode <= 2'h0;
   endtask

   task automatic t_drop();
      wr(12'hb10, 8'hf8);
      send(3'h0, 32'h2222_0000);
      stop();
      wr(12'hb10, 8'hf9);
      wr(12'hb11, 8'h0d);
      send(3'h2, 32'h2222_0001);
      stop();
      repeat (6) @(posedge mclk);
      chk(i_aiq_sram_model.log_q.size(), 0);
      rd(12'hb20, 8'h02);
   endtask

   task automatic t_sel();
      for (int c = 0; c < 4; c++)
      begin
         wr(12'hb11, 8'h41 | 8'(c << 2));
         send(c < 2 ? 3'(c) : 3'h2, 32'h1234_abcd);
         stop();
         got(19'h4_400c + 19'(4*c), c < 2 ? 32'h1234_abcd :
            c == 2 ? 32'h0000_abcd : 32'h0004_abcd);
      end
      wr(12'hb10, 8'hfb);
      wr(12'hb11, 8'hf1);
      send(3'h3, 32'hfff5_4321);
      stop();
      got(19'h4_4800, 32'h0005_4321);
      wr(12'hb11, 8'hd1);
      send(3'h1, 32'hcafe_0001);
      stop();
      got(19'h4_4804, 32'hcafe_0001);
   endtask

   task automatic t_irq();
      wr(12'hb0c, 8'h00);
      wr(12'hb13, 8'h01);
      repeat (3) @(posedge mclk);
      chk(irq, 4'h0);
      wr(12'hb0d, 8'h05);
      repeat (3) @(posedge mclk);
      chk(irq, 4'h2);
      rd(12'hb13, 8'h22);
      wr(12'hb10, 8'hdb);
      repeat (3) @(posedge mclk);
      chk(irq, 4'h0);
      wr(12'hb0d, 8'h60);
      rd(12'hb13, 8'h02);
   endtask

   task automatic t_clk();
      logic a;
      logic b;
      int na;
      int nb;
      na = 0;
      nb = 0;
      chk({sclk_out, codec_mclk_out}, 2'h0);
      wr(12'h068, 8'h02);
      wr(12'h067, 8'h81);
      wr(12'h06d, 8'h04);
      wr(12'h06c, 8'h81);
      a = sclk_out;
      b = codec_mclk_out;
      repeat (100)
      begin
         @(negedge mclk);
         na += int'(sclk_out !== a);
         nb += int'(codec_mclk_out !== b);
         a = sclk_out;
         b = codec_mclk_out;
      end
      chk(na >= 47 && na <= 49, 1'b1);
      chk(nb >= 23 && nb <= 25, 1'b1);
   endtask

   task automatic t_wrap();
      wr(12'hb0a, 8'h01);
      wr(12'hb10, 8'hdf);
      for (int k = 0; k < 4; k++)
         send(3'h4, 32'h3333_0000 + 32'(k));
      stop();
      for (int k = 0; k < 3; k++)
         got(19'h4_3c00 + 19'(4*k), 32'h3333_0000 + 32'(k));
      rd(12'hb24, 8'h03);
      chk(i_aiq_sram_model.log_q.size(), 0);
      pop(3'h4);
      pop(3'h4);
      send(3'h4, 32'h3333_0004);
      send(3'h4, 32'h3333_0005);
      stop();
      got(19'h4_3c0c, 32'h3333_0004);
      got(19'h4_3c00, 32'h3333_0005);
      rd(12'hb24, 8'h03);
   endtask

   // Main sequence
   initial
   begin
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      repeat (4) @(posedge mclk);
      t_reset();
      t_stream();
      t_drop();
      t_sel();
      t_irq();
      t_wrap();
      t_clk();
      conclude();
   end

   // Watchdog against a hang
   initial
   begin
      #100000;
      fail_count++;
      conclude();
   end
endmodule
